// ==== ssla_pkg.sv ====
// Package of constants for the SYSREF one-shot LMFC alignment block.
package ssla_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [11:0] SSLA_SYNC_CTRL_ADDR = 12'h054;
  localparam logic [11:0] SSLA_STATUS_ADDR    = 12'h058;

  // ---------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------
  localparam int          SSLA_ARM_BIT       = 2;
  localparam int          SSLA_SPARE_LSB     = 3;
  localparam int          SSLA_SPARE_MSB     = 6;
  localparam int          SSLA_OFFSET_LSB    = 12;
  localparam int          SSLA_OFFSET_MSB    = 19;
  localparam int          SSLA_BYPASS_BIT    = 20;
  localparam logic        SSLA_ARM_RESET     = 1'b1;
  localparam logic [3:0]  SSLA_SPARE_RESET   = 4'h0;
  localparam logic [7:0]  SSLA_OFFSET_RESET  = 8'h00;

  // ---------------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------------
  localparam int          SSLA_ST_SEEN_BIT   = 0;
  localparam int          SSLA_ST_STATE_LSB  = 1;
  localparam int          SSLA_ST_LMFC_LSB   = 8;

  // ---------------------------------------------------------------------
  // Link states
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    SSLA_CGS  = 2'b00,
    SSLA_ILAS = 2'b01,
    SSLA_DATA = 2'b10
  } ssla_link_e;

  // Last multiframe count of the alignment sequence, which lasts four multiframes.
  localparam logic [1:0]  SSLA_ILAS_MFRAMES  = 2'h3;

endpackage

// ==== ssla_sysref_sync.sv ====
// Two-stage synchroniser with rising-edge detect for the SYSREF pin.
`timescale 1ns/1ps
module ssla_sysref_sync (
  input  wire logic mclk_in,     // Link clock.
  input  wire logic rst_in,      // Synchronous reset, active high.
  input  wire logic sysref_in,   // Asynchronous SYSREF pin.
  output logic      rise_out     // One-cycle pulse on a rising edge.
);

  logic meta;
  logic sync;
  logic prev;
  logic next_rise;

  // Only the second stage reads the first one; the edge test looks at
  // the second and third stages.
  always_comb begin
    next_rise = sync & ~prev;                                   // R12
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      meta     <= 1'b0;
      sync     <= 1'b0;
      prev     <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      meta     <= sysref_in;
      sync     <= meta;
      prev     <= sync;
      rise_out <= next_rise;
    end
  end

  a_edge_shape: assert property (@(posedge mclk_in) disable iff (rst_in)
    rise_out |-> $past(sync) && !$past(prev))                    // R12
    else $error("SYSREF edge pulse without low-high sample pair");

endmodule

// ==== ssla_top.sv ====
// SYSREF one-shot LMFC alignment with APB control and link-state gate.
`timescale 1ns/1ps
// Contract
// R1: With the arm bit set, only one sampled SYSREF rising edge realigns LMFC.
// R2: Hardware clears the arm bit once an edge is sampled while it was set.
// R3: Software must set the arm bit again whenever SYSREF must be resampled.
// R4: The link stays in CGS until at least one SYSREF edge has been sampled; the bypass bit lets it leave without one.
// R5: ILAS is timed from the LMFC counter, which runs freely from reset.
// R6: With the arm bit at 0, SYSREF edges are ignored by the LMFC counter.
// R7: With the arm bit at 1, the first edge resets LMFC and clears the bit.
// R8: Default offset loads zero on alignment; a nonzero offset shifts it. An offset above LMFC_MAX loads zero here instead.
// R9: Four spare read-write bits sit at 6:3, reset to zero, with no effect.
// R10: The arm bit reads 1 after reset so the first edge aligns LMFC.
// R11: A qualifying edge presets the LMFC counter to the programmed offset; the code presets zero for an offset above LMFC_MAX.
// R12: SYSREF is synchronised and an edge is a low sample then a high one.
module ssla_top
  import ssla_pkg::*;
#(
  parameter int LMFC_W   = 8,    // LMFC counter width.
  parameter int LMFC_MAX = 15    // Last LMFC count, (F*K/4)-1.
) (
  input  wire logic        mclk_in,      // Link clock, 40 MHz.
  input  wire logic        rst_in,       // Synchronous reset, active high.
  input  wire logic        psel,         // APB select.
  input  wire logic        penable,      // APB enable.
  input  wire logic        pwrite,       // APB write.
  input  wire logic [11:0] paddr,        // APB byte address.
  input  wire logic [31:0] pwdata,       // APB write data.
  output logic      [31:0] prdata,       // APB read data.
  output logic             pready,       // APB ready.
  output logic             pslverr,      // APB error.
  input  wire logic        sysref_in,    // SYSREF pin.
  input  wire logic        link_go_in,   // Link ready to leave CGS.
  output logic             lmfc_tick_out,// LMFC boundary pulse.
  output logic [1:0]       link_st_out   // Link state.
);
  import ssla_pkg::*;

  // ---------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------
  if (LMFC_W < 1 || LMFC_W > 8 || LMFC_MAX < 1 ||
      LMFC_MAX >= (1 << LMFC_W)) begin : g_bad
    $error("LMFC parameters out of range");
  end

  // ---------------------------------------------------------------------
  // SYSREF edge detect
  // ---------------------------------------------------------------------
  logic sysref_rise;

  ssla_sysref_sync u_sync (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .sysref_in (sysref_in),
    .rise_out  (sysref_rise)
  );

  // ---------------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------------
  logic              arm;
  logic [3:0]        spare;
  logic [7:0]        offset;
  logic              bypass;
  logic              seen;
  logic [LMFC_W-1:0] lmfc;
  ssla_link_e        state;
  logic [1:0]        mf_cnt;

  logic              next_arm;
  logic [3:0]        next_spare;
  logic [7:0]        next_offset;
  logic              next_bypass;
  logic              next_seen;
  logic [LMFC_W-1:0] next_lmfc;
  ssla_link_e        next_state;
  logic [1:0]        next_mf_cnt;
  logic [31:0]       next_prdata;
  logic              next_pready;
  logic              next_pslverr;
  logic              next_tick;

  logic              wr_ctrl;
  logic              align;
  logic [LMFC_W-1:0] preset;
  logic              wrap;

  // The response is given one cycle after the enable phase starts, so each
  // access is two phases long plus one wait state.
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == SSLA_SYNC_CTRL_ADDR) || (a == SSLA_STATUS_ADDR);
  endfunction

  always_comb begin
    wr_ctrl = psel && penable && !pready && pwrite &&
              (paddr == SSLA_SYNC_CTRL_ADDR);
    align   = sysref_rise && arm;                                // R1 R6
    // An offset beyond the multiframe falls back to zero.
    if (32'(offset) > 32'(LMFC_MAX)) begin
      preset = '0;
    end else begin
      preset = offset[LMFC_W-1:0];                               // R8 R11
    end
    wrap = (32'(lmfc) == 32'(LMFC_MAX));
  end

  // ---------------------------------------------------------------------
  // Control register and arm bit
  // ---------------------------------------------------------------------
  always_comb begin
    next_arm    = arm;
    next_spare  = spare;
    next_offset = offset;
    next_bypass = bypass;
    if (wr_ctrl) begin
      next_arm    = pwdata[SSLA_ARM_BIT];                        // R3
      next_spare  = pwdata[SSLA_SPARE_MSB:SSLA_SPARE_LSB];       // R9
      next_offset = pwdata[SSLA_OFFSET_MSB:SSLA_OFFSET_LSB];
      next_bypass = pwdata[SSLA_BYPASS_BIT];
    end
    // The hardware clear wins over a software write in the same cycle
    // only if that write also cleared the bit; a write of 1 re-arms.
    if (align && !(wr_ctrl && pwdata[SSLA_ARM_BIT])) begin
      next_arm = 1'b0;                                           // R2 R7
    end
    next_seen = seen | sysref_rise;
  end

  // ---------------------------------------------------------------------
  // LMFC counter and link state
  // ---------------------------------------------------------------------
  always_comb begin
    next_lmfc   = wrap ? '0 : lmfc + 1'b1;                       // R5
    next_tick   = wrap;
    if (align) begin
      next_lmfc = preset;                                        // R11
      next_tick = 1'b0;
    end
    next_state  = state;
    next_mf_cnt = mf_cnt;
    unique case (state)
      SSLA_CGS: begin
        // Leaving CGS before SYSREF is caught gives nondeterministic
        // latency, hence the gate on the sampled-edge flag.
        if (link_go_in && wrap && (seen || bypass)) begin        // R4
          next_state  = SSLA_ILAS;
          next_mf_cnt = '0;
        end
      end
      SSLA_ILAS: begin
        if (wrap) begin                                          // R5
          next_mf_cnt = mf_cnt + 2'h1;
          if (mf_cnt == SSLA_ILAS_MFRAMES) begin
            next_state = SSLA_DATA;
          end
        end
      end
      SSLA_DATA: begin
        next_state = SSLA_DATA;
      end
      default: begin
        next_state = SSLA_CGS;
      end
    endcase
    if (!link_go_in) begin
      next_state = SSLA_CGS;
    end
  end

  // ---------------------------------------------------------------------
  // APB responder
  // ---------------------------------------------------------------------
  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (psel && penable && !pready) begin
      next_pready  = 1'b1;
      next_pslverr = !mapped(paddr);
      if (!pwrite && paddr == SSLA_SYNC_CTRL_ADDR) begin
        next_prdata[SSLA_ARM_BIT]                   = arm;
        next_prdata[SSLA_SPARE_MSB:SSLA_SPARE_LSB]  = spare;    // R9
        next_prdata[SSLA_OFFSET_MSB:SSLA_OFFSET_LSB] = offset;
        next_prdata[SSLA_BYPASS_BIT]                = bypass;
      end else if (!pwrite && paddr == SSLA_STATUS_ADDR) begin
        next_prdata[SSLA_ST_SEEN_BIT]    = seen;
        next_prdata[SSLA_ST_STATE_LSB+:2] = state;
        next_prdata[SSLA_ST_LMFC_LSB+:8] = 8'(lmfc);
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      arm           <= SSLA_ARM_RESET;                           // R10
      spare         <= SSLA_SPARE_RESET;                         // R9
      offset        <= SSLA_OFFSET_RESET;
      bypass        <= 1'b0;
      seen          <= 1'b0;
      lmfc          <= '0;
      state         <= SSLA_CGS;
      mf_cnt        <= '0;
      prdata        <= 32'h0000_0000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      lmfc_tick_out <= 1'b0;
      link_st_out   <= SSLA_CGS;
    end else begin
      arm           <= next_arm;
      spare         <= next_spare;
      offset        <= next_offset;
      bypass        <= next_bypass;
      seen          <= next_seen;
      lmfc          <= next_lmfc;
      state         <= next_state;
      mf_cnt        <= next_mf_cnt;
      prdata        <= next_prdata;
      pready        <= next_pready;
      pslverr       <= next_pslverr;
      lmfc_tick_out <= next_tick;
      link_st_out   <= next_state;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  sequence s_armed_edge;
    sysref_rise && arm;
  endsequence

  a_single_align: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_armed_edge ##1 (!$past(wr_ctrl) || !$past(pwdata[SSLA_ARM_BIT]))
    |-> !arm)                                                    // R2
    else $error("Arm bit not cleared after aligning edge");

  // Edges need at least two cycles apart, so the later edge is looked for
  // over a window rather than in the very next cycles.
  a_second_edge: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_armed_edge ##[2:100] (sysref_rise && !arm && !wrap)
    |=> lmfc == $past(lmfc) + 1'b1)                               // R1
    else $error("Second SYSREF edge realigned LMFC");

  a_ignore_edge: assert property (@(posedge mclk_in) disable iff (rst_in)
    (sysref_rise && !arm && !wrap) |=> lmfc == $past(lmfc) + 1'b1) // R6
    else $error("Unarmed SYSREF edge touched LMFC");

  a_preset_value: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_armed_edge |=> lmfc == $past(preset))                      // R7 R8
    else $error("LMFC not preset on armed edge");

  a_preset_offs: assert property (@(posedge mclk_in) disable iff (rst_in)
    (s_armed_edge and offset == 8'h00) |=> lmfc == '0)           // R11
    else $error("Zero offset did not load zero");

  a_cgs_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == SSLA_CGS && !seen && !bypass) |=> state == SSLA_CGS) // R4
    else $error("Left CGS before any SYSREF edge");

  a_free_run: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!align && !wrap) |=> lmfc == $past(lmfc) + 1'b1)            // R5
    else $error("LMFC counter not free running");

  a_arm_reset: assert property (@(posedge mclk_in)
    $past(rst_in) |-> arm && spare == 4'h0)                      // R10 R9
    else $error("Arm or spare bits wrong after reset");

  a_spare_inert: assert property (@(posedge mclk_in) disable iff (rst_in)
    $changed(spare) |-> $past(wr_ctrl))                          // R9
    else $error("Spare bits changed without a write");

endmodule

// ==== ssla_sysref_src.sv ====
// Behavioural SYSREF source for the link block.
`timescale 1ns/1ps
module ssla_sysref_src (
  input  wire logic       mclk_in,    // Reference clock.
  input  wire logic       fire_in,    // Start one SYSREF pulse.
  input  wire logic [3:0] hold_in,    // High time in cycles, 2 or more.
  output logic            sysref_out  // SYSREF level to the block.
);
  logic [3:0] left = 4'h0;

  // The level moves only after an edge, so every pulse spans whole cycles.
  always @(posedge mclk_in) begin
    if (fire_in) begin
      left <= hold_in;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end
  assign sysref_out = (left != 4'h0);
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the SYSREF one-shot LMFC alignment block.
`timescale 1ns/1ps
module tb_top;
  import ssla_pkg::*;
  logic        mclk_in = 1'b0;
  logic        rst_in  = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic        link_go = 1'b1;
  logic        fire    = 1'b0;
  logic [3:0]  hold    = 4'h2;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sysref;
  logic        tick;
  logic [1:0]  link_st;
  logic [31:0] rd;
  logic        er;
  int          err_total = 0;
  int          comparisons = 0;
  int          m_arm, m_sp, m_off, d0, d1, d2, n, o1, o2;

  always #12.5 mclk_in = ~mclk_in;

  ssla_top #(.LMFC_W(8), .LMFC_MAX(15)) u_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sysref_in(sysref),
    .link_go_in(link_go), .lmfc_tick_out(tick), .link_st_out(link_st));

  ssla_sysref_src u_src (.mclk_in(mclk_in), .fire_in(fire),
    .hold_in(hold), .sysref_out(sysref));

  // ---------------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------------
  task chk(input string what, input logic [31:0] seen,
           input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task close_out;
    $display("Checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk_in);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do begin
      @(posedge mclk_in);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", {31'h0, pready}, 32'h1);
  endtask

  function automatic logic [31:0] ctrl_v();
    return 32'((m_arm << SSLA_ARM_BIT) | (m_sp << SSLA_SPARE_LSB)
               | (m_off << SSLA_OFFSET_LSB));
  endfunction

  task rd_chk(input string what, input logic [11:0] a,
              input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd & m, exp);
  endtask

  // Upper reserved bits get random junk; they must read back as zero.
  task wr_ctrl(input int arm, input int sp, input int off);
    m_arm = arm; m_sp = sp; m_off = off;
    apb(1'b1, SSLA_SYNC_CTRL_ADDR, ctrl_v() | {11'($urandom), 21'h0});
  endtask

  task do_reset(input int c);
    rst_in <= 1'b1;
    repeat (c) @(posedge mclk_in);
    rst_in <= 1'b0;
    m_arm = 1; m_sp = 0; m_off = 0;
  endtask

  // Ticks before the new phase can land are skipped in the first 6 edges.
  task align(output int d);
    @(posedge mclk_in);
    fire <= 1'b1;
    hold <= 4'(2 + $urandom % 6);
    d = 0;
    do begin
      @(posedge mclk_in);
      fire <= 1'b0;
      d++;
    end while ((d < 7 || tick !== 1'b1) && d < 60);
    m_arm = 0;
  endtask

  task tick_gap(input logic f, output int d);
    int k;
    k = 0;
    do begin
      @(posedge mclk_in);
      k++;
    end while (tick !== 1'b1 && k < 40);
    fire <= f;
    d = 0;
    do begin
      @(posedge mclk_in);
      fire <= 1'b0;
      d++;
    end while (tick !== 1'b1 && d < 60);
  endtask

  task st_chk(input logic [1:0] s, input int lim);
    int k;
    k = 0;
    while (link_st !== s && k < lim) begin
      @(posedge mclk_in);
      k++;
    end
    chk("link_st", {30'h0, link_st}, {30'h0, s});
  endtask

  // ---------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------
  initial begin
    n = $urandom(75055);
    do_reset(5);
    rd_chk("ctrl", SSLA_SYNC_CTRL_ADDR, 32'hFFFFFFFF, ctrl_v());
    apb(1'b1, 12'h0F0, 32'hFFFFFFFF);
    chk("slverr", {31'h0, er}, 32'h1);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", rd, 32'h0);
    rd_chk("ctrl", SSLA_SYNC_CTRL_ADDR, 32'hFFFFFFFF, ctrl_v());
    rd_chk("seen", SSLA_STATUS_ADDR, 32'h7, 32'h0);
    repeat (60) @(posedge mclk_in);
    st_chk(SSLA_CGS, 0);
    o1 = $urandom % 5;
    o2 = o1 + 1 + $urandom % 6;
    wr_ctrl(1, $urandom % 16, o1);
    rd_chk("ctrl", SSLA_SYNC_CTRL_ADDR, 32'hFFFFFFFF, ctrl_v());
    align(d1);
    rd_chk("ctrl", SSLA_SYNC_CTRL_ADDR, 32'hFFFFFFFF, ctrl_v());
    rd_chk("seen", SSLA_STATUS_ADDR, 32'h1, 32'h1);
    tick_gap(1'b0, n);
    chk("period", 32'(n), 32'd16);
    st_chk(SSLA_DATA, 120);
    wr_ctrl(1, m_sp, o2);
    align(d2);
    chk("offset", 32'(d1 - d2), 32'(o2 - o1));
    wr_ctrl(0, $urandom % 16, 0);
    tick_gap(1'b1, n);
    chk("disarmed", 32'(n), 32'd16);
    wr_ctrl(1, m_sp, 0);
    align(d0);
    chk("zero", 32'(d0), 32'(d1 + o1));
    // Four edges to the preset, sixteen counts, the tick register and
    // the edge that samples it.
    chk("latency", 32'(d0), 32'd22);
    rd_chk("ctrl", SSLA_SYNC_CTRL_ADDR, 32'hFFFFFFFF, ctrl_v());
    link_go <= 1'b0;
    repeat (3) @(posedge mclk_in);
    st_chk(SSLA_CGS, 0);
    link_go <= 1'b1;
    do_reset(2);
    rd_chk("ctrl", SSLA_SYNC_CTRL_ADDR, 32'hFFFFFFFF, ctrl_v());
    repeat (60) @(posedge mclk_in);
    st_chk(SSLA_CGS, 0);
    close_out;
  end

  // The whole run needs under 500 cycles; 5000 means a hang.
  initial begin
    #125000;
    err_total++;
    close_out;
  end
endmodule
